// ---- rtl/dmr_defs.svh ----
`ifndef DMR_DEFS_SVH
`define DMR_DEFS_SVH

// ------------------------------------------------------------
// Mode addresses
// ------------------------------------------------------------
`define DMR_MA_W            6
`define DMR_MA_SEG_MASK     6'h11
`define DMR_MA_OSC_LOW      6'h12
`define DMR_MA_OSC_HIGH     6'h13
`define DMR_MA_UB_INVERT    6'h14

// ------------------------------------------------------------
// Reset values and field positions
// ------------------------------------------------------------
`define DMR_SEG_MASK_RST    8'h00
`define DMR_UB_INVERT_RST   8'h55
`define DMR_SEG_ROW_HI      14
`define DMR_SEG_ROW_LO      12
`define DMR_SEG_UPPER_HI    7
`define DMR_SEG_UPPER_LO    6

// ------------------------------------------------------------
// Link opcodes
// ------------------------------------------------------------
`define DMR_OP_W            3
`define DMR_OP_MRW          3'h0
`define DMR_OP_MRR          3'h1
`define DMR_OP_OSC_START    3'h2
`define DMR_OP_OSC_STOP     3'h3
`define DMR_OP_CAL_READ     3'h4
`define DMR_OP_OSC_READ     3'h5

// ------------------------------------------------------------
// Controller registers (AXI4-Lite byte offsets) and fields
// ------------------------------------------------------------
`define DMR_REG_CMD         4'h0
`define DMR_REG_STATUS      4'h4
`define DMR_REG_CONFIG      4'h8
`define DMR_REG_RESULT      4'hC
`define DMR_CMD_OP_LO       0
`define DMR_CMD_CHAN        3
`define DMR_CMD_ADDR_LO     4
`define DMR_CMD_DATA_LO     10

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define DMR_LINK_HALF_CYC   8'd4

`endif

// ---- rtl/dmr_pkg.sv ----
package dmr_pkg;

	// Controller sequencer states
	typedef enum logic [1:0] {
		DMR_H_IDLE,
		DMR_H_ISSUE,
		DMR_H_HOLD,
		DMR_H_WAIT
	} dmr_host_fsm_t;

	// Device end state
	typedef struct packed {
		logic [19:0]      sync1;
		logic [19:0]      sync2;
		logic             clk_prev;
		logic [1:0][7:0]  seg_mask;
		logic [7:0]       ub_invert;
		logic             osc_run;
		logic [15:0]      osc_cnt;
		logic [7:0]       rsp_data;
		logic             rsp_dmi;
		logic             rsp_tog;
		logic             rsp_pend;
		logic [2:0]       beat;
		logic             seg_en;
	} dmr_dev_state_t;

	// Controller end state
	typedef struct packed {
		logic [7:0]       div_cnt;
		logic             lclk;
		logic             cs;
		logic [2:0]       op;
		logic             chan;
		logic [5:0]       addr;
		logic [7:0]       wdata;
		logic [9:0]       sync1;
		logic [9:0]       sync2;
		logic             tog_seen;
		dmr_host_fsm_t    fsm;
		logic             step;
		logic [17:0]      cmd;
		logic             busy;
		logic             done;
		logic             limit;
		logic [15:0]      result;
		logic             res_dmi;
		logic             awready;
		logic             wready;
		logic             aw_got;
		logic             w_got;
		logic [3:0]       aw_addr;
		logic [31:0]      w_data;
		logic             bvalid;
		logic [1:0]       bresp;
		logic             arready;
		logic             rvalid;
		logic [31:0]      rdata;
		logic [1:0]       rresp;
	} dmr_host_state_t;

endpackage : dmr_pkg

// ---- rtl/dmr_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none

interface dmr_link_if;
	// Controller to device
	logic        link_clk;
	logic        cs;
	logic [2:0]  op;
	logic        chan;
	logic [5:0]  addr;
	logic [7:0]  wdata;
	// Device to controller
	logic        rsp_tog;
	logic [7:0]  rsp_data;
	logic        rsp_dmi;

	modport host (
		output link_clk, cs, op, chan, addr, wdata,
		input  rsp_tog, rsp_data, rsp_dmi
	);
	modport dev (
		input  link_clk, cs, op, chan, addr, wdata,
		output rsp_tog, rsp_data, rsp_dmi
	);
endinterface : dmr_link_if

`default_nettype wire

// ---- rtl/dmr_device.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dmr_defs.svh"

// Function
// - Write-only segment mask, zero keeps refresh
// - Mask bit n gates segment R14:R12
// - Separate segment mask for each channel
// - Controller clears mask bits 7:6 when limited
// - Count low byte readable at 12H
// - Count high byte readable at 13H
// - Controller reads both bytes and concatenates
// - Oscillator start command clears both bytes
// - Controller may retune strobe from count
// - Write-only upper-byte invert at 14H
// - Invert register defaults to 55H
// - Invert bits 0..7 map DQ8..DQ15
// - Mask/inversion lane never inverted in calibration
// - No bus inversion during read calibration

module dmr_device (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Link to controller
	dmr_link_if.dev          link,
	// Refresh engine query
	input  wire logic        refresh_chan,
	input  wire logic [14:0] refresh_row,
	output var  logic        seg_refresh_en,
	// Calibration and io configuration
	input  wire logic [7:0]  calib_pattern_a,
	input  wire logic        dbi_enable,
	// Oscillator status
	output var  logic        osc_running,
	output var  logic [15:0] osc_count
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	dmr_pkg::dmr_dev_state_t s_q;
	dmr_pkg::dmr_dev_state_t s_d;

	localparam dmr_pkg::dmr_dev_state_t RESET_STATE = '{
		sync1:     20'h0_0000,
		sync2:     20'h0_0000,
		clk_prev:  1'b0,
		seg_mask:  {`DMR_SEG_MASK_RST, `DMR_SEG_MASK_RST},
		ub_invert: `DMR_UB_INVERT_RST,
		osc_run:   1'b0,
		osc_cnt:   16'h0000,
		rsp_data:  8'h00,
		rsp_dmi:   1'b0,
		rsp_tog:   1'b0,
		rsp_pend:  1'b0,
		beat:      3'h0,
		seg_en:    1'b1
	};

	// Highest count the oscillator holds
	localparam logic [15:0] OSC_MAX = 16'hFFFF;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Invert a byte with more than four ones, so fewer lines switch
	function automatic logic [8:0] dbi_code(input logic [7:0] b, input logic en);
		logic flip;
		flip = en && ($countones(b) > 4);
		return {flip, flip ? ~b : b};
	endfunction : dbi_code

	// ------------------------------------------------------------
	// Decoded view of synchronised link pins
	// ------------------------------------------------------------
	logic        l_clk;
	logic        l_cs;
	logic [2:0]  l_op;
	logic        l_chan;
	logic [5:0]  l_addr;
	logic [7:0]  l_wdata;
	logic        l_rise;

	// Only the second stage is read, never the first
	assign {l_clk, l_cs, l_op, l_chan, l_addr, l_wdata} = s_q.sync2;
	assign l_rise = l_clk && !s_q.clk_prev;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	// Commands act on the sampled rising edge of the link clock
	always_comb begin
		logic [2:0] seg;
		logic       pat_bit;
		logic [7:0] rd_byte;
		seg     = refresh_row[`DMR_SEG_ROW_HI:`DMR_SEG_ROW_LO];
		pat_bit = calib_pattern_a[s_q.beat];
		rd_byte = 8'h00;
		s_d     = s_q;

		s_d.sync1    = {link.link_clk, link.cs, link.op, link.chan, link.addr, link.wdata};
		s_d.sync2    = s_q.sync1;
		s_d.clk_prev = l_clk;

		// ------------------------------------------------------------
		// Refresh query
		// ------------------------------------------------------------
		// Zero bit keeps the segment refreshed
		s_d.seg_en = !s_q.seg_mask[refresh_chan][seg];

		// ------------------------------------------------------------
		// Oscillator
		// ------------------------------------------------------------
		// Saturate rather than wrap so a long run never looks short
		if (s_q.osc_run && s_q.osc_cnt != OSC_MAX) begin
			s_d.osc_cnt = s_q.osc_cnt + 16'h0001;
		end

		// ------------------------------------------------------------
		// Answer handshake
		// ------------------------------------------------------------
		// Data settles one cycle before the toggle flips
		if (s_q.rsp_pend) begin
			s_d.rsp_tog  = !s_q.rsp_tog;
			s_d.rsp_pend = 1'b0;
		end

		// ------------------------------------------------------------
		// Command decode
		// ------------------------------------------------------------
		if (l_rise && l_cs) begin
			case (l_op)
				`DMR_OP_MRW: begin
					case (l_addr)
						`DMR_MA_SEG_MASK: begin
							s_d.seg_mask[l_chan] = l_wdata;
						end
						`DMR_MA_UB_INVERT: begin
							s_d.ub_invert = l_wdata;
						end
						default: begin
						end
					endcase
				end
				`DMR_OP_MRR: begin
					// Write-only registers read back as zero
					case (l_addr)
						`DMR_MA_OSC_LOW: begin
							rd_byte = s_q.osc_cnt[7:0];
						end
						`DMR_MA_OSC_HIGH: begin
							rd_byte = s_q.osc_cnt[15:8];
						end
						default: begin
							rd_byte = 8'h00;
						end
					endcase
					// Ordinary reads honour bus inversion when enabled
					{s_d.rsp_dmi, s_d.rsp_data} = dbi_code(rd_byte, dbi_enable);
					s_d.rsp_pend = 1'b1;
				end
				`DMR_OP_OSC_START: begin
					s_d.osc_cnt = 16'h0000;
					s_d.osc_run = 1'b1;
				end
				`DMR_OP_OSC_STOP: begin
					s_d.osc_run = 1'b0;
				end
				`DMR_OP_CAL_READ: begin
					// Bit i of invert flips line DQ(8+i); lane bit stays true
					s_d.rsp_data = s_q.ub_invert ^ {8{pat_bit}};
					s_d.rsp_dmi  = pat_bit;
					s_d.beat     = s_q.beat + 3'h1;
					s_d.rsp_pend = 1'b1;
				end
				default: begin
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	// Synchronous reset restores documented defaults
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= RESET_STATE;
		end else begin
			s_q <= s_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// All straight from flops
	assign link.rsp_tog   = s_q.rsp_tog;
	assign link.rsp_data  = s_q.rsp_data;
	assign link.rsp_dmi   = s_q.rsp_dmi;
	assign seg_refresh_en = s_q.seg_en;
	assign osc_running    = s_q.osc_run;
	assign osc_count      = s_q.osc_cnt;

endmodule : dmr_device

`default_nettype wire

// ---- rtl/dmr_host.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dmr_defs.svh"

module dmr_host (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output var  logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output var  logic        s_axi_wready,
	output var  logic [1:0]  s_axi_bresp,
	output var  logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output var  logic        s_axi_arready,
	output var  logic [31:0] s_axi_rdata,
	output var  logic [1:0]  s_axi_rresp,
	output var  logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Link to device
	dmr_link_if.host         link
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	dmr_pkg::dmr_host_state_t s_q;
	dmr_pkg::dmr_host_state_t s_d;

	localparam dmr_pkg::dmr_host_state_t RESET_STATE = '{
		fsm: dmr_pkg::DMR_H_IDLE, awready: 1'b1, wready: 1'b1, arready: 1'b1,
		default: '0
	};

	logic       fall;
	logic       r_tog;
	logic       r_dmi;
	logic [7:0] r_data;
	logic       op_osc;

	// Falling link edge is where pins change
	assign fall   = (s_q.div_cnt == `DMR_LINK_HALF_CYC - 8'd1) && s_q.lclk;
	assign {r_tog, r_dmi, r_data} = s_q.sync2;
	assign op_osc = s_q.cmd[2:0] == `DMR_OP_OSC_READ;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic [7:0] wd;
		wd  = s_q.cmd[17:10];
		s_d = s_q;

		// Free-running divided link clock
		if (s_q.div_cnt == `DMR_LINK_HALF_CYC - 8'd1) begin
			s_d.div_cnt = 8'd0;
			s_d.lclk    = !s_q.lclk;
		end else begin
			s_d.div_cnt = s_q.div_cnt + 8'd1;
		end
		s_d.sync1 = {link.rsp_tog, link.rsp_dmi, link.rsp_data};
		s_d.sync2 = s_q.sync1;

		// AXI write: address and data in either order
		if (s_axi_awvalid && s_q.awready) begin
			s_d.aw_got  = 1'b1;
			s_d.aw_addr = s_axi_awaddr;
			s_d.awready = 1'b0;
		end
		if (s_axi_wvalid && s_q.wready) begin
			s_d.w_got  = 1'b1;
			s_d.w_data = s_axi_wdata;
			s_d.wready = 1'b0;
		end
		if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
			s_d.bvalid = 1'b1;
			s_d.bresp  = 2'b00;
			// Unaligned offsets fall to the default and are refused
			case (s_q.aw_addr)
				`DMR_REG_CMD: begin
					// Ignored while a command is under way
					if (!s_q.busy) begin
						s_d.cmd  = s_q.w_data[17:0];
						s_d.busy = 1'b1;
						s_d.done = 1'b0;
						s_d.step = 1'b0;
						s_d.fsm  = dmr_pkg::DMR_H_ISSUE;
					end
				end
				`DMR_REG_CONFIG: s_d.limit = s_q.w_data[0];
				`DMR_REG_STATUS: begin
				end
				default: s_d.bresp = 2'b10;
			endcase
		end
		if (s_q.bvalid && s_axi_bready) begin
			s_d.bvalid  = 1'b0;
			s_d.aw_got  = 1'b0;
			s_d.w_got   = 1'b0;
			s_d.awready = 1'b1;
			s_d.wready  = 1'b1;
		end

		// AXI read
		if (s_axi_arvalid && s_q.arready) begin
			s_d.arready = 1'b0;
			s_d.rvalid  = 1'b1;
			s_d.rresp   = 2'b00;
			case (s_axi_araddr)
				`DMR_REG_CMD:    s_d.rdata = {14'h0000, s_q.cmd};
				`DMR_REG_STATUS: s_d.rdata = {30'h0000_0000, s_q.done, s_q.busy};
				`DMR_REG_CONFIG: s_d.rdata = {31'h0000_0000, s_q.limit};
				`DMR_REG_RESULT: s_d.rdata = {15'h0000, s_q.res_dmi, s_q.result};
				default: begin
					s_d.rdata = 32'h0000_0000;
					s_d.rresp = 2'b10;
				end
			endcase
		end
		if (s_q.rvalid && s_axi_rready) begin
			s_d.rvalid  = 1'b0;
			s_d.arready = 1'b1;
		end

		// Upper segments are illegal on limited densities
		if (s_q.limit && s_q.cmd[`DMR_CMD_ADDR_LO+:6] == `DMR_MA_SEG_MASK) begin
			wd[`DMR_SEG_UPPER_HI:`DMR_SEG_UPPER_LO] = 2'b00;
		end

		// Link sequencer
		case (s_q.fsm)
			dmr_pkg::DMR_H_IDLE: begin
			end
			dmr_pkg::DMR_H_ISSUE: begin
				if (fall) begin
					s_d.cs    = 1'b1;
					s_d.chan  = s_q.cmd[`DMR_CMD_CHAN];
					s_d.wdata = wd;
					// Count comes as two reads, low first
					s_d.op    = op_osc ? `DMR_OP_MRR : s_q.cmd[2:0];
					s_d.addr  = op_osc ? (s_q.step ? `DMR_MA_OSC_HIGH : `DMR_MA_OSC_LOW)
						: s_q.cmd[`DMR_CMD_ADDR_LO+:6];
					s_d.fsm   = dmr_pkg::DMR_H_HOLD;
				end
			end
			dmr_pkg::DMR_H_HOLD: begin
				if (fall) begin
					s_d.cs = 1'b0;
					if (s_q.op == `DMR_OP_MRR || s_q.op == `DMR_OP_CAL_READ) begin
						s_d.fsm = dmr_pkg::DMR_H_WAIT;
					end else begin
						s_d.busy = 1'b0;
						s_d.done = 1'b1;
						s_d.fsm  = dmr_pkg::DMR_H_IDLE;
					end
				end
			end
			dmr_pkg::DMR_H_WAIT: begin
				if (r_tog != s_q.tog_seen) begin
					s_d.tog_seen = r_tog;
					s_d.res_dmi  = r_dmi;
					if (op_osc && !s_q.step) begin
						s_d.result[7:0] = r_data;
						s_d.step        = 1'b1;
						s_d.fsm         = dmr_pkg::DMR_H_ISSUE;
					end else begin
						if (op_osc) begin
							s_d.result[15:8] = r_data;
						end else begin
							s_d.result = {8'h00, r_data};
						end
						s_d.busy = 1'b0;
						s_d.done = 1'b1;
						s_d.fsm  = dmr_pkg::DMR_H_IDLE;
					end
				end
			end
			default: s_d.fsm = dmr_pkg::DMR_H_IDLE;
		endcase
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= RESET_STATE;
		end else begin
			s_q <= s_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign s_axi_awready = s_q.awready;
	assign s_axi_wready  = s_q.wready;
	assign s_axi_bvalid  = s_q.bvalid;
	assign s_axi_bresp   = s_q.bresp;
	assign s_axi_arready = s_q.arready;
	assign s_axi_rvalid  = s_q.rvalid;
	assign s_axi_rdata   = s_q.rdata;
	assign s_axi_rresp   = s_q.rresp;
	assign link.link_clk = s_q.lclk;
	assign link.cs       = s_q.cs;
	assign link.op       = s_q.op;
	assign link.chan     = s_q.chan;
	assign link.addr     = s_q.addr;
	assign link.wdata    = s_q.wdata;

endmodule : dmr_host

`default_nettype wire

// ---- dv/dmr_link_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dmr_defs.svh"

module dmr_link_asserts (
	// Clock and reset
	input wire logic       aclk,
	input wire logic       aresetn,
	// Controller to device
	input wire logic       link_clk,
	input wire logic       cs,
	input wire logic [2:0] op,
	input wire logic       chan,
	input wire logic [5:0] addr,
	input wire logic [7:0] wdata,
	// Device to controller
	input wire logic       rsp_tog,
	input wire logic [7:0] rsp_data,
	input wire logic       rsp_dmi
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// ------------------------------------------------------------
	// Command issue steps
	// ------------------------------------------------------------
	sequence rd_issue_s;
		$rose(cs) && (op == `DMR_OP_MRR || op == `DMR_OP_CAL_READ);
	endsequence
	sequence wr_issue_s;
		$rose(cs) && op == `DMR_OP_MRW;
	endsequence

	// Link protocol checks
	link_idle_rst_a: assert property ($rose(aresetn) |-> !cs && !link_clk && !rsp_tog)
		else $error("link not idle after reset");
	clk_half_a: assert property ($changed(link_clk) |=> $stable(link_clk) [*3])
		else $error("link clock half period short");
	cs_on_fall_a: assert property ($rose(cs) |-> $fell(link_clk))
		else $error("select not on falling edge");
	cs_width_a: assert property ($rose(cs) |-> cs [*8])
		else $error("select shorter than a link period");
	cmd_stable_a: assert property (cs && $past(cs) |-> $stable({op, chan, addr, wdata}))
		else $error("command moved while selected");
	rsp_settled_a: assert property ($changed(rsp_tog) |-> $stable({rsp_data, rsp_dmi}))
		else $error("answer moved with its toggle");
	rd_answer_a: assert property (rd_issue_s |-> ##[4:24] $changed(rsp_tog))
		else $error("read not answered in time");
	wr_silent_a: assert property (wr_issue_s |=> (!$changed(rsp_tog)) [*8] ##1 (!$changed(rsp_tog)) [*8])
		else $error("write produced an answer");
endmodule : dmr_link_asserts

`default_nettype wire

// ---- dv/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "dmr_defs.svh"

module tb;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	typedef struct packed {
		logic [2:0]  op;
		logic        ch;
		logic [5:0]  a;
		logic [7:0]  wd;
		logic        rd;
		logic [16:0] e;
	} dmr_tb_row_t;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, refresh_chan, dbi_enable;
	logic        seg_refresh_en, osc_running;
	logic [3:0]  awaddr, araddr, wstrb;
	logic [31:0] wdata, rdata, d;
	logic [1:0]  bresp, rresp;
	logic [14:0] refresh_row;
	logic [7:0]  calib_pattern_a;
	logic [15:0] osc_count;
	int          num_errors, n_compared, cyc, c0;
	dmr_tb_row_t rows [7] = '{
		'{`DMR_OP_MRW, 1'b0, `DMR_MA_SEG_MASK, 8'hA5, 1'b0, 17'h0_0000},
		'{`DMR_OP_MRW, 1'b1, `DMR_MA_SEG_MASK, 8'h3C, 1'b0, 17'h0_0000},
		'{`DMR_OP_MRW, 1'b0, `DMR_MA_UB_INVERT, 8'h01, 1'b0, 17'h0_0000},
		'{`DMR_OP_MRR, 1'b0, `DMR_MA_SEG_MASK, 8'h00, 1'b1, 17'h0_0000},
		'{`DMR_OP_MRR, 1'b0, `DMR_MA_UB_INVERT, 8'h00, 1'b1, 17'h0_0000},
		'{`DMR_OP_MRR, 1'b0, 6'h2A, 8'h00, 1'b1, 17'h0_0000},
		'{`DMR_OP_CAL_READ, 1'b0, 6'h00, 8'h00, 1'b1, 17'h1_00FE}};

	// Both ends face each other on one link
	dmr_link_if dmr_link_if_inst ();
	dmr_host dmr_host_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .link(dmr_link_if_inst));
	dmr_device dmr_device_inst (.aclk(aclk), .aresetn(aresetn), .link(dmr_link_if_inst),
		.refresh_chan(refresh_chan), .refresh_row(refresh_row),
		.seg_refresh_en(seg_refresh_en), .calib_pattern_a(calib_pattern_a),
		.dbi_enable(dbi_enable), .osc_running(osc_running), .osc_count(osc_count));
	dmr_link_asserts dmr_link_asserts_inst (.aclk(aclk), .aresetn(aresetn),
		.link_clk(dmr_link_if_inst.link_clk), .cs(dmr_link_if_inst.cs),
		.op(dmr_link_if_inst.op), .chan(dmr_link_if_inst.chan),
		.addr(dmr_link_if_inst.addr), .wdata(dmr_link_if_inst.wdata),
		.rsp_tog(dmr_link_if_inst.rsp_tog), .rsp_data(dmr_link_if_inst.rsp_data),
		.rsp_dmi(dmr_link_if_inst.rsp_dmi));

	// 125 MHz clock and a free cycle count
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	always @(posedge aclk) cyc <= cyc + 1;

	// ------------------------------------------------------------
	// Tasks: all but chk start and end just after a rising edge
	// ------------------------------------------------------------
	task automatic final_report();
		$display("Compared %0d, errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : final_report

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			$display("Error at %0t: got %h expected %h", $time, got, exp);
			num_errors++;
		end
	endtask : chk

	// Bus inversion as ordinary reads apply it: {high lane bit, high, low}
	function automatic logic [16:0] dbi_exp(input logic [15:0] v);
		logic hi;
		logic lo;
		hi = $countones(v[15:8]) > 4;
		lo = $countones(v[7:0]) > 4;
		return {hi, hi ? ~v[15:8] : v[15:8], lo ? ~v[7:0] : v[7:0]};
	endfunction : dbi_exp

	// Ready is sampled on the falling edge, where it is settled until the handshake
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] er);
		logic aw, w, b;
		awaddr  <= a;
		wdata   <= v;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		for (int n = 0; n < 64; n++) begin
			@(negedge aclk);
			aw = awvalid && awready;
			w  = wvalid && wready;
			b  = bvalid;
			if (b)
				chk(32'(bresp), 32'(er));
			@(posedge aclk);
			if (aw)
				awvalid <= 1'b0;
			if (w)
				wvalid <= 1'b0;
			if (b) begin
				bready <= 1'b0;
				// One idle edge so the next call never re-raises bready at once
				@(posedge aclk);
				return;
			end
		end
		num_errors++;
		final_report();
	endtask : axi_wr

	task automatic axi_rd(input logic [3:0] a, output logic [31:0] v, input logic [1:0] er);
		logic ar, r;
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		for (int n = 0; n < 64; n++) begin
			@(negedge aclk);
			ar = arvalid && arready;
			r  = rvalid;
			v  = rdata;
			if (r)
				chk(32'(rresp), 32'(er));
			@(posedge aclk);
			if (ar)
				arvalid <= 1'b0;
			if (r) begin
				rready <= 1'b0;
				// One idle edge so the next call never re-raises rready at once
				@(posedge aclk);
				return;
			end
		end
		num_errors++;
		final_report();
	endtask : axi_rd

	// Command word, then poll the sticky done flag
	task automatic run_cmd(input logic [2:0] op, input logic ch, input logic [5:0] a,
		input logic [7:0] wd);
		logic [31:0] st;
		axi_wr(`DMR_REG_CMD, {14'h0000, wd, a, ch, op}, 2'b00);
		for (int n = 0; n < 40; n++) begin
			axi_rd(`DMR_REG_STATUS, st, 2'b00);
			if (st[1] === 1'b1)
				return;
		end
		num_errors++;
		final_report();
	endtask : run_cmd

	task automatic res_chk(input logic [16:0] e);
		axi_rd(`DMR_REG_RESULT, d, 2'b00);
		chk(32'(d[16:0]), 32'(e));
	endtask : res_chk

	// Walk all eight segments, two clocks of query latency allowed
	task automatic seg_chk(input logic ch, input logic [7:0] m);
		for (int s = 0; s < 8; s++) begin
			refresh_chan <= ch;
			refresh_row  <= {3'(s), 12'hA5A};
			repeat (2) @(posedge aclk);
			@(negedge aclk);
			chk(32'(seg_refresh_en), 32'(!m[s]));
			@(posedge aclk);
		end
	endtask : seg_chk

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, refresh_chan, aresetn} = '0;
		{awaddr, araddr, wdata, refresh_row} = '0;
		wstrb           = 4'hF;
		calib_pattern_a = 8'h02;
		dbi_enable      = 1'b1;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		// Defaults: all segments refreshed, invert 55H with pattern bit 0
		seg_chk(1'b0, 8'h00);
		seg_chk(1'b1, 8'h00);
		run_cmd(`DMR_OP_CAL_READ, 1'b0, 6'h00, 8'h00);
		res_chk(17'h0_0055);
		// Ordinary commands; the calibration row uses pattern bit 1 with bus inversion on
		foreach (rows[i]) begin
			run_cmd(rows[i].op, rows[i].ch, rows[i].a, rows[i].wd);
			if (rows[i].rd)
				res_chk(rows[i].e);
		end
		seg_chk(1'b0, 8'hA5);
		seg_chk(1'b1, 8'h3C);
		// Limit forces the two upper mask bits low
		axi_wr(`DMR_REG_CONFIG, 32'h0000_0001, 2'b00);
		run_cmd(`DMR_OP_MRW, 1'b0, `DMR_MA_SEG_MASK, 8'hFF);
		seg_chk(1'b0, 8'h3F);
		axi_wr(`DMR_REG_CONFIG, 32'h0000_0000, 2'b00);
		// Unaligned offset is refused
		axi_wr(4'h2, 32'h0000_1234, 2'b10);
		axi_rd(4'h2, d, 2'b10);
		chk(d, 32'h0000_0000);
		// Count runs past one byte; inversion off so bytes come back raw
		dbi_enable <= 1'b0;
		run_cmd(`DMR_OP_OSC_START, 1'b0, 6'h00, 8'h00);
		c0 = cyc;
		repeat (600) @(posedge aclk);
		run_cmd(`DMR_OP_OSC_STOP, 1'b0, 6'h00, 8'h00);
		c0 = cyc - c0;
		run_cmd(`DMR_OP_OSC_READ, 1'b0, 6'h00, 8'h00);
		axi_rd(`DMR_REG_RESULT, d, 2'b00);
		chk(32'(int'(d[15:0]) > c0 - 24 && int'(d[15:0]) < c0 + 24), 32'h1);
		chk(32'(osc_running), 32'h0);
		// Same frozen count read again with bus inversion on
		c0 = int'(d[15:0]);
		dbi_enable <= 1'b1;
		run_cmd(`DMR_OP_OSC_READ, 1'b0, 6'h00, 8'h00);
		res_chk(dbi_exp(c0[15:0]));
		// A fresh start clears both bytes
		run_cmd(`DMR_OP_OSC_START, 1'b0, 6'h00, 8'h00);
		@(negedge aclk);
		chk(32'(osc_count < 16'h0030 && osc_running), 32'h1);
		@(posedge aclk);
		// Second reset in mid-run brings back the defaults
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		chk(32'(osc_count), 32'h0);
		@(posedge aclk);
		seg_chk(1'b0, 8'h00);
		run_cmd(`DMR_OP_CAL_READ, 1'b0, 6'h00, 8'h00);
		res_chk(17'h0_0055);
		final_report();
	end
endmodule : tb

`default_nettype wire
